// >>> rtl/dtc_defines.svh
// Purpose: named constants of the detector test trigger control
// Assumes: 20 MHz system clock, airflow given in percent of reference
// Notes: definitions only
`ifndef DTC_DEFINES_SVH
`define DTC_DEFINES_SVH

// ****************************************
// timing
// ****************************************
`define DTC_CLK_HZ 32'h0131_2D00
`define DTC_SEC_CYC (`DTC_CLK_HZ)
`define DTC_FLASH_HZ 32'h0000_0002
`define DTC_FLASH_HALF_CYC (`DTC_CLK_HZ / (32'h0000_0002 * `DTC_FLASH_HZ))
`define DTC_AF_DELAY_S 9'h12C
`define DTC_CONFIRM_S 3'h5

// ****************************************
// airflow window, percent of reference
// ****************************************
`define DTC_AF_HIGH 8'h78
`define DTC_AF_LOW 8'h50

// ****************************************
// selector positions and last press count
// ****************************************
`define DTC_POS_OPER 5'h01
`define DTC_POS_FAULT 5'h03
`define DTC_POS_PRE 5'h04
`define DTC_POS_ALARM 5'h05

`define DTC_PRESS_LAST 2'h2

`endif

// >>> rtl/dtc_pkg.sv
// Purpose: types of the detector test trigger control
// Assumes: nothing
// Notes: constants live in dtc_defines.svh
package dtc_pkg;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic alarm;
		logic fault;
		logic presignal;
	} dtc_panel_t;

	typedef struct packed {
		logic alarm_led;
		logic fault_led;
		logic mode_led;
	} dtc_led_t;

	typedef enum logic [1:0] {
		DTC_SEL_IDLE,
		DTC_SEL_WAIT,
		DTC_SEL_FLASH
	} dtc_sel_t;

endpackage

// >>> rtl/dtc_tick_gen.sv
// Purpose: one-second enable pulse and flash phase for the test control
// Assumes: single clock, synchronous reset
// Notes: counts are parameters so a simulation can shorten them
`timescale 1ns/1ns
`include "dtc_defines.svh"

module dtc_tick_gen #(
	parameter int SEC_CYC = `DTC_SEC_CYC,
	parameter int HALF_CYC = `DTC_FLASH_HALF_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	output logic sec_tick,
	output logic flash_ph
);

	logic [24:0] sec_cnt_r, sec_cnt_nxt;
	logic [24:0] half_cnt_r, half_cnt_nxt;
	logic sec_tick_nxt, flash_ph_nxt;

	always_comb
	begin
		sec_cnt_nxt = sec_cnt_r + 25'h000_0001;
		sec_tick_nxt = 1'b0;
		half_cnt_nxt = half_cnt_r + 25'h000_0001;
		flash_ph_nxt = flash_ph;
		if (sec_cnt_r == 25'(SEC_CYC - 1))
		begin
			sec_cnt_nxt = 25'h000_0000;
			sec_tick_nxt = 1'b1;
		end
		if (half_cnt_r == 25'(HALF_CYC - 1))
		begin
			half_cnt_nxt = 25'h000_0000;
			flash_ph_nxt = ~flash_ph;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sec_cnt_r <= 25'h000_0000;
			half_cnt_r <= 25'h000_0000;
			sec_tick <= 1'b0;
			flash_ph <= 1'b0;
		end
		else
		begin
			sec_cnt_r <= sec_cnt_nxt;
			half_cnt_r <= half_cnt_nxt;
			sec_tick <= sec_tick_nxt;
			flash_ph <= flash_ph_nxt;
		end
	end

endmodule // dtc_tick_gen

// >>> rtl/dtc_test_ctrl.sv
// Purpose: test triggers, airflow supervision and selector supervision
// Assumes: inputs synchronous to clk_sys, confirm_key already debounced
// Notes: events latch until the fire panel clears them
`timescale 1ns/1ns
`include "dtc_defines.svh"

module dtc_test_ctrl #(
	parameter int SEC_CYC = `DTC_SEC_CYC,
	parameter int HALF_CYC = `DTC_FLASH_HALF_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [4:0] selector,
	input wire logic confirm_key,
	input wire logic [7:0] airflow_pct,
	input wire logic panel_clear,
	input wire logic line_module_en,
	output dtc_pkg::dtc_panel_t relay_out,
	output dtc_pkg::dtc_panel_t optional_line_module,
	output dtc_pkg::dtc_led_t leds,
	output logic selector_fault,
	output logic test_mode
);

	// ****************************************
	// time base
	// ****************************************
	logic sec_tick, flash_ph;

	dtc_tick_gen #(
		.SEC_CYC(SEC_CYC),
		.HALF_CYC(HALF_CYC)
	) u_tick (
		.clk_sys(clk_sys),
		.rst(rst),
		.sec_tick(sec_tick),
		.flash_ph(flash_ph)
	);

	// ****************************************
	// state
	// ****************************************
	logic [4:0] sel_prev_r, sel_prev_nxt;
	logic key_prev_r, key_prev_nxt;
	logic [1:0] press_cnt_r, press_cnt_nxt;
	logic alarm_r, alarm_nxt;
	logic fault_r, fault_nxt;
	logic pre_r, pre_nxt;
	logic af_fault_r, af_fault_nxt;
	logic [8:0] af_sec_r, af_sec_nxt;
	dtc_pkg::dtc_sel_t sel_st_r, sel_st_nxt;
	logic [2:0] sel_sec_r, sel_sec_nxt;
	logic sel_fault_r, sel_fault_nxt;
	logic test_mode_r, test_mode_nxt;
	dtc_pkg::dtc_panel_t panel_nxt, line_nxt;
	dtc_pkg::dtc_led_t leds_nxt;

	logic press, sel_moved, af_dev, test_pos;

	function automatic logic is_test_pos(input logic [4:0] pos);
		is_test_pos = (pos == `DTC_POS_FAULT) || (pos == `DTC_POS_PRE) ||
			(pos == `DTC_POS_ALARM);
	endfunction

	always_comb
	begin
		press = confirm_key & ~key_prev_r;
		sel_moved = selector != sel_prev_r;
		test_pos = is_test_pos(selector);
		af_dev = (airflow_pct > `DTC_AF_HIGH) || (airflow_pct < `DTC_AF_LOW);

		sel_prev_nxt = selector;
		key_prev_nxt = confirm_key;
		press_cnt_nxt = press_cnt_r;
		alarm_nxt = alarm_r;
		fault_nxt = fault_r;
		pre_nxt = pre_r;
		af_fault_nxt = af_fault_r;
		af_sec_nxt = af_sec_r;
		sel_st_nxt = sel_st_r;
		sel_sec_nxt = sel_sec_r;
		sel_fault_nxt = sel_fault_r;
		test_mode_nxt = test_mode_r;

		// the panel is the only party that clears latched events
		if (panel_clear)
		begin
			alarm_nxt = 1'b0;
			fault_nxt = 1'b0;
			pre_nxt = 1'b0;
			sel_fault_nxt = 1'b0;
			if (!af_dev)
				af_fault_nxt = 1'b0;
		end

		// airflow supervision; time restarts whenever flow is back in window
		if (!af_dev)
			af_sec_nxt = 9'h000;
		else if (sec_tick && af_sec_r != `DTC_AF_DELAY_S)
			af_sec_nxt = af_sec_r + 9'h001;
		if (af_dev && af_sec_r == `DTC_AF_DELAY_S)
			af_fault_nxt = 1'b1;

		// press counting, only on a steady test position
		if (sel_moved || !test_pos)
			press_cnt_nxt = 2'h0;
		else if (press)
		begin
			if (press_cnt_r == `DTC_PRESS_LAST)
			begin
				press_cnt_nxt = 2'h0;
				test_mode_nxt = 1'b1;
				if (selector == `DTC_POS_ALARM)
					alarm_nxt = 1'b1;
				if (selector == `DTC_POS_FAULT)
					fault_nxt = 1'b1;
				if (selector == `DTC_POS_PRE)
					pre_nxt = 1'b1;
			end
			else
				press_cnt_nxt = press_cnt_r + 2'h1;
		end

		// operating position confirmed: leave test, keep latched events
		if (!sel_moved && press && selector == `DTC_POS_OPER)
			test_mode_nxt = 1'b0;

		// selector supervision
		unique case (sel_st_r)
			dtc_pkg::DTC_SEL_IDLE:
			begin
				if (sel_moved)
				begin
					sel_st_nxt = dtc_pkg::DTC_SEL_WAIT;
					sel_sec_nxt = 3'h0;
				end
			end
			dtc_pkg::DTC_SEL_WAIT, dtc_pkg::DTC_SEL_FLASH:
			begin
				// a new position always earns a fresh confirm window
				if (sel_moved)
				begin
					sel_st_nxt = dtc_pkg::DTC_SEL_WAIT;
					sel_sec_nxt = 3'h0;
				end
				else if (press)
					sel_st_nxt = dtc_pkg::DTC_SEL_IDLE;
				else if (sec_tick)
				begin
					if (sel_sec_r == `DTC_CONFIRM_S - 3'h1)
					begin
						sel_sec_nxt = 3'h0;
						if (sel_st_r == dtc_pkg::DTC_SEL_WAIT)
							sel_st_nxt = dtc_pkg::DTC_SEL_FLASH;
						else
						begin
							sel_st_nxt = dtc_pkg::DTC_SEL_IDLE;
							sel_fault_nxt = 1'b1;
						end
					end
					else
						sel_sec_nxt = sel_sec_r + 3'h1;
				end
			end
			default:
				sel_st_nxt = dtc_pkg::DTC_SEL_IDLE;
		endcase

		// outputs, one cycle behind the latched state
		panel_nxt.alarm = alarm_r;
		panel_nxt.fault = fault_r | af_fault_r | sel_fault_r;
		panel_nxt.presignal = pre_r;
		line_nxt = line_module_en ? panel_nxt : '0;
		leds_nxt.alarm_led = alarm_r | (pre_r & flash_ph);
		if (fault_r || af_fault_r || sel_fault_r)
			leds_nxt.fault_led = 1'b1;
		else
			leds_nxt.fault_led = af_dev & flash_ph;
		leds_nxt.mode_led = (sel_st_r == dtc_pkg::DTC_SEL_FLASH) & flash_ph;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			sel_prev_r <= `DTC_POS_OPER;
			key_prev_r <= 1'b0;
			press_cnt_r <= 2'h0;
			alarm_r <= 1'b0;
			fault_r <= 1'b0;
			pre_r <= 1'b0;
			af_fault_r <= 1'b0;
			af_sec_r <= 9'h000;
			sel_st_r <= dtc_pkg::DTC_SEL_IDLE;
			sel_sec_r <= 3'h0;
			sel_fault_r <= 1'b0;
			test_mode_r <= 1'b0;
			relay_out <= '0;
			optional_line_module <= '0;
			leds <= '0;
			selector_fault <= 1'b0;
			test_mode <= 1'b0;
		end
		else
		begin
			sel_prev_r <= sel_prev_nxt;
			key_prev_r <= key_prev_nxt;
			press_cnt_r <= press_cnt_nxt;
			alarm_r <= alarm_nxt;
			fault_r <= fault_nxt;
			pre_r <= pre_nxt;
			af_fault_r <= af_fault_nxt;
			af_sec_r <= af_sec_nxt;
			sel_st_r <= sel_st_nxt;
			sel_sec_r <= sel_sec_nxt;
			sel_fault_r <= sel_fault_nxt;
			test_mode_r <= test_mode_nxt;
			relay_out <= panel_nxt;
			optional_line_module <= line_nxt;
			leds <= leds_nxt;
			selector_fault <= sel_fault_r;
			test_mode <= test_mode_r;
		end
	end

endmodule // dtc_test_ctrl

// >>> tb/dtc_ctrl_sva.sv
// Purpose: port checks of the test control
// Assumes: one clock
// Notes: bound by the bench
`timescale 1ns/1ns
module dtc_ctrl_sva #(
	parameter int SEC_CYC = 40,
	parameter int HALF_CYC = 10
) (
	input logic clk_sys,
	input logic rst,
	input logic [4:0] selector,
	input logic confirm_key,
	input logic panel_clear,
	input logic line_module_en,
	input dtc_pkg::dtc_panel_t relay_out,
	input dtc_pkg::dtc_panel_t optional_line_module,
	input dtc_pkg::dtc_led_t leds,
	input logic selector_fault,
	input logic test_mode
);
	// ****
	// checks
	// ****
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	property p_al;
		$rose(relay_out.alarm) |-> $past(selector, 2) == 5'h05 && $past(confirm_key, 2);
	endproperty
	a_al: assert property (p_al) else $error("alarm cause");
	property p_pr;
		$rose(relay_out.presignal) |-> $past(selector, 2) == 5'h04 && $past(confirm_key, 2);
	endproperty
	a_pr: assert property (p_pr) else $error("presignal cause");
	property p_ft;
		$rose(relay_out.fault) && $past(selector, 2) == 5'h03 |-> leds.fault_led;
	endproperty
	a_ft: assert property (p_ft) else $error("fault led");
	// the clear pulse is masked for two edges since outputs lag it
	property p_hold;
		relay_out.alarm && !panel_clear && !$past(panel_clear) |=> relay_out.alarm;
	endproperty
	a_hold: assert property (p_hold) else $error("alarm dropped");
	property p_ex;
		$fell(test_mode) |-> $past(selector, 2) == 5'h01;
	endproperty
	a_ex: assert property (p_ex) else $error("test mode exit");
	property p_lm;
		line_module_en && $past(line_module_en) |-> optional_line_module == relay_out;
	endproperty
	a_lm: assert property (p_lm) else $error("line module copy");
	property p_lo;
		!line_module_en && !$past(line_module_en) |-> optional_line_module == 3'h0;
	endproperty
	a_lo: assert property (p_lo) else $error("line module off");
	property p_sf;
		selector_fault && !$past(panel_clear) && !$past(panel_clear, 2) |-> leds.fault_led;
	endproperty
	a_sf: assert property (p_sf) else $error("selector fault led");
	c_al: cover property ($rose(relay_out.alarm));
	c_pr: cover property ($rose(relay_out.presignal));
	c_sf: cover property ($rose(selector_fault));
	c_ft: cover property ($rose(relay_out.fault));
endmodule // dtc_ctrl_sva

// >>> tb/dtc_panel_model.sv
// Purpose: fire panel on the relay outputs
// Assumes: one clock
// Notes: clears events only on request
`timescale 1ns/1ns
module dtc_panel_model (
	input logic clk_sys,
	input dtc_pkg::dtc_panel_t relay_out,
	input logic clear_req,
	output logic panel_clear
);
	initial panel_clear = 1'b0;
	// a local reset never clears us, only this pulse does; reset only what is shown
	always @(posedge clk_sys)
		panel_clear <= clear_req & (|relay_out);
endmodule // dtc_panel_model

// >>> tb/tb_detector_test_trigger_control.sv
// Purpose: bench of the test trigger control
// Assumes: short second and flash counts
// Notes: one task per scenario
`timescale 1ns/1ns
module tb_detector_test_trigger_control;
	// ****
	// bench
	// ****
	localparam int SEC = 40;
	logic clk_sys = 1'b0, rst = 1'b1, confirm_key = 1'b0, clear_req = 1'b0;
	logic line_module_en = 1'b1, panel_clear, selector_fault, test_mode;
	logic [4:0] selector = 5'h01;
	logic [7:0] airflow_pct = 8'h64, k;
	dtc_pkg::dtc_panel_t relay_out, optional_line_module;
	dtc_pkg::dtc_led_t leds;
	int n_mismatch = 0, compares = 0;
	dtc_test_ctrl #(.SEC_CYC(SEC), .HALF_CYC(10)) uut (.*);
	dtc_panel_model panel (.*);
	initial forever #25 clk_sys = ~clk_sys;
	task cyc(int n);
		repeat (n) @(negedge clk_sys);
	endtask
	task chk(string s, logic [7:0] g, logic [7:0] e);
		compares++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s exp %h got %h", s, e, g);
		end
	endtask
	task print_verdict;
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task press;
		confirm_key = 1'b1;
		cyc(1);
		confirm_key = 1'b0;
		cyc(1);
	endtask
	task op;
		selector = 5'h01;
		cyc(2);
		press();
		cyc(2);
	endtask
	task clr;
		clear_req = 1'b1;
		cyc(1);
		clear_req = 1'b0;
		cyc(4);
	endtask
	// 40 cycles hold two whole flash periods, so a flashing led counts 20
	task ones(int b);
		k = 8'h00;
		repeat (40)
		begin
			cyc(1);
			k = k + leds[b];
		end
	endtask
	task upto(int n);
		repeat (n)
		begin
			if (relay_out.fault === 1'b1)
				return;
			cyc(1);
		end
		n_mismatch++;
		print_verdict();
	endtask
	task trig(logic [4:0] pos, logic [2:0] ev, int b, logic [7:0] lit);
		selector = pos;
		cyc(2);
		repeat (3) press();
		cyc(2);
		chk("relay", relay_out, ev);
		chk("test mode on", test_mode, 1'b1);
		chk("line", optional_line_module, line_module_en ? ev : 3'h0);
		ones(b);
		chk("led", k, lit);
		op();
		chk("test mode", test_mode, 1'b0);
		chk("held", relay_out, ev);
		clr();
		chk("clear", relay_out, 3'h0);
	endtask
	task discard;
		selector = 5'h05;
		cyc(2);
		repeat (2) press();
		selector = 5'h04;
		cyc(2);
		press();
		cyc(3);
		chk("discard", relay_out, 3'h0);
		repeat (2) press();
		cyc(2);
		chk("recount", relay_out, 3'h1);
		op();
		clr();
	endtask
	task af(logic [7:0] v, logic [7:0] lit);
		airflow_pct = v;
		cyc(3);
		ones(1);
		chk("airflow led", k, lit);
		airflow_pct = 8'h64;
		cyc(3);
	endtask
	task af_long;
		airflow_pct = 8'h4F;
		cyc(298 * SEC);
		chk("early", relay_out.fault, 1'b0);
		upto(3 * SEC);
		chk("af fault", relay_out.fault, 1'b1);
		clr();
		chk("af held", relay_out.fault, 1'b1);
		airflow_pct = 8'h64;
		cyc(2);
		clr();
		chk("af cleared", relay_out.fault, 1'b0);
	endtask
	task selfault;
		selector = 5'h03;
		cyc(6 * SEC);
		ones(0);
		chk("mode led", k, 8'h14);
		upto(6 * SEC);
		cyc(2);
		chk("sel fault", {selector_fault, leds.fault_led}, 2'h3);
	endtask
	initial
	begin
		cyc(20);
		rst = 1'b0;
		cyc(2);
		chk("reset", {relay_out, leds, selector_fault, test_mode}, 8'h00);
		trig(5'h05, 3'h4, 2, 8'h28);
		line_module_en = 1'b0;
		trig(5'h03, 3'h2, 1, 8'h28);
		line_module_en = 1'b1;
		trig(5'h04, 3'h1, 2, 8'h14);
		discard();
		af(8'h78, 8'h00);
		af(8'h50, 8'h00);
		af(8'h79, 8'h14);
		af_long();
		selfault();
		print_verdict();
	end
endmodule // tb_detector_test_trigger_control
bind dtc_test_ctrl dtc_ctrl_sva #(.SEC_CYC(SEC_CYC), .HALF_CYC(HALF_CYC)) sva_i (.*);
